// ==== logic/three_phase_pwm_timing_unit.sv ====
`default_nettype none
// Notes on behaviour
// - one pclk is one tick; half period
// - half period register sixteen bits wide
// - turn-on delayed by dead time times two
// - dead time register ten bits wide
// - zero dead time gives no gap
// - one dead time for all pairs
// - mode bit six selects double update
// - reset clears mode bit: single update
// - one sync per period in single mode, marks start
// - sync rise copies registers to working set
// - sync rise also copies segment control
// - double mode adds midpoint sync pulse
// - midpoint sync reloads working values too
// - status bit three marks second half in double mode only
// - sync lasts width plus one ticks
// - sync width resets to 0x27
// - three sixteen-bit duty registers
// - sync pulse routed to converter output
// - on-time from duty minus dead, clamped
// - idle until period and duties written
// - sync pulse raises processor request
module three_phase_pwm_timing_unit #(
  parameter int addr_w = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [addr_w-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   phase_a_high_out,
  output logic                   phase_a_low_out,
  output logic                   phase_b_high_out,
  output logic                   phase_b_low_out,
  output logic                   phase_c_high_out,
  output logic                   phase_c_low_out,
  output logic                   cycle_sync_pulse,
  output logic                   converter_sync,
  output logic                   sync_irq,
  output logic [8:0]             segment_out
);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [15:0] switching_half_period;
  logic [9:0]  dead_time_setting;
  logic [15:0] minimum_pulse_setting;
  logic [7:0]  sync_pulse_width;
  logic [15:0] duty_phase_a;
  logic [15:0] duty_phase_b;
  logic [15:0] duty_phase_c;
  logic [8:0]  output_segment_control;
  logic [15:0] peripheral_mode_register;
  logic [3:0]  written;
  logic        second_half;
  logic        running;

  logic        wr_en;
  logic        rd_en;
  logic        addr_hit;
  logic [7:0]  addr8;

  assign addr8 = paddr[7:0];
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign addr_hit = (addr8[1:0] == 2'h0)
                    && (addr8 <= pwm_timing_pkg::off_status);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      switching_half_period    <= 16'h0000;
      dead_time_setting        <= 10'h000;
      minimum_pulse_setting    <= 16'h0000;
      sync_pulse_width         <= pwm_timing_pkg::sync_width_rst;
      duty_phase_a             <= 16'h0000;
      duty_phase_b             <= 16'h0000;
      duty_phase_c             <= 16'h0000;
      output_segment_control   <= 9'h000;
      peripheral_mode_register <= 16'h0000;
      written                  <= 4'h0;
    end
    else if (wr_en)
    begin
      unique case (addr8)
        pwm_timing_pkg::off_half_period:
        begin
          switching_half_period <= pwdata[15:0];
          written[0] <= 1'b1;
        end
        pwm_timing_pkg::off_dead_time:
          dead_time_setting <= pwdata[9:0];
        pwm_timing_pkg::off_min_pulse:
          minimum_pulse_setting <= pwdata[15:0];
        pwm_timing_pkg::off_sync_width:
          sync_pulse_width <= pwdata[7:0];
        pwm_timing_pkg::off_duty_a:
        begin
          duty_phase_a <= pwdata[15:0];
          written[1] <= 1'b1;
        end
        pwm_timing_pkg::off_duty_b:
        begin
          duty_phase_b <= pwdata[15:0];
          written[2] <= 1'b1;
        end
        pwm_timing_pkg::off_duty_c:
        begin
          duty_phase_c <= pwdata[15:0];
          written[3] <= 1'b1;
        end
        pwm_timing_pkg::off_segment:
          output_segment_control <= pwdata[8:0];
        pwm_timing_pkg::off_mode:
          peripheral_mode_register <= pwdata[15:0];
        default:
          peripheral_mode_register <= peripheral_mode_register;
      endcase
    end
  end

  // two-cycle access: setup decodes, access answers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_hit;
      if (rd_en)
      begin
        unique case (addr8)
          pwm_timing_pkg::off_half_period:
            prdata <= {16'h0000, switching_half_period};
          pwm_timing_pkg::off_dead_time:
            prdata <= {22'h000000, dead_time_setting};
          pwm_timing_pkg::off_min_pulse:
            prdata <= {16'h0000, minimum_pulse_setting};
          pwm_timing_pkg::off_sync_width:
            prdata <= {24'h000000, sync_pulse_width};
          pwm_timing_pkg::off_duty_a: prdata <= {16'h0000, duty_phase_a};
          pwm_timing_pkg::off_duty_b: prdata <= {16'h0000, duty_phase_b};
          pwm_timing_pkg::off_duty_c: prdata <= {16'h0000, duty_phase_c};
          pwm_timing_pkg::off_segment:
            prdata <= {23'h000000, output_segment_control};
          pwm_timing_pkg::off_mode:
            prdata <= {16'h0000, peripheral_mode_register};
          pwm_timing_pkg::off_status:
            prdata <= {28'h0000000, second_half, 2'h0, running};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // up/down counter and reload
  logic        double_mode;
  logic [15:0] count;
  logic        counting_down;
  logic        load;
  logic [15:0] work_period;
  logic [9:0]  work_dead;
  logic [15:0] work_min_pulse;
  logic [7:0]  work_sync_width;
  logic [15:0] work_duty [3];
  logic [8:0]  sync_count;
  logic        period_start;
  logic        midpoint;
  logic        at_top;

  assign double_mode
    = peripheral_mode_register[pwm_timing_pkg::mode_double_bit];
  assign at_top = count >= work_period;
  assign period_start = running && counting_down && (count <= 16'h0001);
  assign midpoint = running && !counting_down && at_top;
  // a start is forced when the unit first becomes enabled
  assign load = (!running && (&written)) || period_start
                || (midpoint && double_mode);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      running       <= 1'b0;
      count         <= 16'h0000;
      counting_down <= 1'b0;
      second_half   <= 1'b0;
    end
    else if (&written)
    begin
      running <= 1'b1;
      if (!running || period_start)
      begin
        count         <= 16'h0001;
        counting_down <= 1'b0;
        second_half   <= 1'b0;
      end
      else if (midpoint)
      begin
        // top count held one more tick: each half lasts the full value
        count         <= count;
        counting_down <= 1'b1;
        second_half   <= double_mode;
      end
      else if (counting_down)
        count <= count - 16'h0001;
      else
        count <= count + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      work_period     <= 16'h0000;
      work_dead       <= 10'h000;
      work_min_pulse  <= 16'h0000;
      work_sync_width <= 8'h00;
      work_duty[0]    <= 16'h0000;
      work_duty[1]    <= 16'h0000;
      work_duty[2]    <= 16'h0000;
      segment_out     <= 9'h000;
    end
    else if (load)
    begin
      work_period     <= switching_half_period;
      work_dead       <= dead_time_setting;
      work_min_pulse  <= minimum_pulse_setting;
      work_sync_width <= sync_pulse_width;
      work_duty[0]    <= duty_phase_a;
      work_duty[1]    <= duty_phase_b;
      work_duty[2]    <= duty_phase_c;
      segment_out     <= output_segment_control;
    end
  end

  // sync pulse: width plus one ticks from the reload edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_count       <= 9'h000;
      cycle_sync_pulse <= 1'b0;
      converter_sync   <= 1'b0;
      sync_irq         <= 1'b0;
    end
    else
    begin
      if (load)
        sync_count <= {1'b0, sync_pulse_width};
      else if (sync_count != 9'h000)
        sync_count <= sync_count - 9'h001;
      cycle_sync_pulse <= load || (cycle_sync_pulse && sync_count != 9'h000);
      converter_sync   <= load
                          || (cycle_sync_pulse && sync_count != 9'h000);
      sync_irq         <= load;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-phase compare and dead time
  logic [2:0] high_raw;
  logic [2:0] high_q;
  logic [2:0] low_q;

  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++)
    begin : g_phase
      logic [16:0] on_half;
      logic [10:0] dead_ticks;
      logic [10:0] hi_wait;
      logic [10:0] lo_wait;
      logic        prev_raw;
      // duty is half the centred on-window; clamp to the half period
      assign on_half = (work_duty[ph] > work_period)
                       ? {1'b0, work_period} : {1'b0, work_duty[ph]};
      // count above period minus duty places edges symmetrically
      assign high_raw[ph] = running
                            && ({1'b0, count} + on_half > {1'b0, work_period});
      assign dead_ticks = 11'(work_dead)
                          * 11'(pwm_timing_pkg::dead_tick_mult);

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          prev_raw   <= 1'b0;
          hi_wait    <= 11'h000;
          lo_wait    <= 11'h000;
          high_q[ph] <= 1'b0;
          low_q[ph]  <= 1'b0;
        end
        else if (!running)
        begin
          prev_raw   <= 1'b0;
          high_q[ph] <= 1'b0;
          low_q[ph]  <= 1'b0;
        end
        else
        begin
          prev_raw <= high_raw[ph];
          // low side is the complement; each rise waits out the dead time
          if (high_raw[ph] && !prev_raw)
          begin
            low_q[ph]  <= 1'b0;
            hi_wait    <= dead_ticks;
            high_q[ph] <= (dead_ticks == 11'h000);
          end
          else if (!high_raw[ph] && prev_raw)
          begin
            high_q[ph] <= 1'b0;
            lo_wait    <= dead_ticks;
            low_q[ph]  <= (dead_ticks == 11'h000);
          end
          else
          begin
            if (hi_wait > 11'h001)
              hi_wait <= hi_wait - 11'h001;
            else if (hi_wait == 11'h001)
            begin
              hi_wait    <= 11'h000;
              high_q[ph] <= high_raw[ph];
            end
            if (lo_wait > 11'h001)
              lo_wait <= lo_wait - 11'h001;
            else if (lo_wait == 11'h001)
            begin
              lo_wait   <= 11'h000;
              low_q[ph] <= !high_raw[ph];
            end
          end
        end
      end
    end
  endgenerate

  assign phase_a_high_out = high_q[0];
  assign phase_a_low_out  = low_q[0];
  assign phase_b_high_out = high_q[1];
  assign phase_b_low_out  = low_q[1];
  assign phase_c_high_out = high_q[2];
  assign phase_c_low_out  = low_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_pair_never_both: assert property (
    !(high_q[0] && low_q[0]))
    else $error("phase a both sides on");
  a_idle_until_ready: assert property (
    !(&written) |-> !cycle_sync_pulse && !high_q[0] && !low_q[0])
    else $error("output before setup complete");
  a_mode_default: assert property (
    $rose(presetn) |-> !double_mode)
    else $error("mode not single after reset");
  a_sync_irq_pair: assert property (
    sync_irq |-> cycle_sync_pulse && $past(load))
    else $error("irq without sync");
  a_conv_follows: assert property (
    converter_sync == cycle_sync_pulse)
    else $error("converter sync mismatch");
  a_hold_between: assert property (
    !$past(load) && running && $past(running) |-> $stable(work_duty[0]))
    else $error("working duty changed off sync");
  a_single_no_mid: assert property (
    midpoint && !double_mode && running && !period_start |=> !sync_irq)
    else $error("midpoint sync in single mode");
  a_double_mid: assert property (
    midpoint && double_mode |=> sync_irq && second_half)
    else $error("midpoint sync missing");
  a_sync_width: assert property (
    load && sync_pulse_width == 8'h00
    |=> ##1 !cycle_sync_pulse || $past(load))
    else $error("sync width wrong");

endmodule : three_phase_pwm_timing_unit
`default_nettype wire

// ==== logic/pwm_timing_pkg.sv ====
`default_nettype none
package pwm_timing_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] off_half_period = 8'h00;
  localparam logic [7:0] off_dead_time   = 8'h04;
  localparam logic [7:0] off_min_pulse   = 8'h08;
  localparam logic [7:0] off_sync_width  = 8'h0c;
  localparam logic [7:0] off_duty_a      = 8'h10;
  localparam logic [7:0] off_duty_b      = 8'h14;
  localparam logic [7:0] off_duty_c      = 8'h18;
  localparam logic [7:0] off_segment     = 8'h1c;
  localparam logic [7:0] off_mode        = 8'h20;
  localparam logic [7:0] off_status      = 8'h24;
  localparam int         half_period_w   = 16;
  localparam int         dead_time_w     = 10;
  localparam int         sync_width_w    = 8;
  localparam int         segment_w       = 9;
  localparam int         mode_double_bit = 6;
  localparam int         status_half_bit = 3;
  localparam int         status_run_bit  = 0;
  localparam logic [7:0] sync_width_rst  = 8'h27;
  localparam int         dead_tick_mult  = 2;
endpackage : pwm_timing_pkg
`default_nettype wire

// ==== testbench/gate_drive_model.sv ====
`default_nettype none
module gate_drive_model (
  input  wire logic pclk,
  input  wire logic ah,
  input  wire logic al,
  input  wire logic bh,
  input  wire logic bl,
  input  wire logic ch,
  input  wire logic cl,
  output var  int   shoot_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  initial shoot_cnt = 0;
  // both switches of a leg on would short the dc link
  always @(negedge pclk)
    if ((ah && al) || (bh && bl) || (ch && cl))
      shoot_cnt++;
endmodule : gate_drive_model
`default_nettype wire

// ==== testbench/three_phase_pwm_timing_unit_tb.sv ====
`default_nettype none
module three_phase_pwm_timing_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ah, al, bh, bl, ch, cl;
  logic        sync, csync, irq;
  logic [8:0]  seg;
  logic [31:0] rd;
  logic        er;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          shoot;
  int          m_per, m_wid, m_ha, m_la, m_hb, m_hc, m_irq, m_mis;

  three_phase_pwm_timing_unit DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .phase_a_high_out(ah),
    .phase_a_low_out(al), .phase_b_high_out(bh), .phase_b_low_out(bl),
    .phase_c_high_out(ch), .phase_c_low_out(cl),
    .cycle_sync_pulse(sync), .converter_sync(csync), .sync_irq(irq),
    .segment_out(seg));
  gate_drive_model gates (.pclk(pclk), .ah(ah), .al(al), .bh(bh),
    .bl(bl), .ch(ch), .cl(cl), .shoot_cnt(shoot));

  always #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // only the watchdog ends a stalled transfer
      do
        @(posedge pclk);
      while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    check(rd, exp);
  endtask : rdchk

  task automatic wait_rise;
    int n;
    begin
      n = 0;
      while (sync !== 1'h0 && n < 400)
      begin
        @(negedge pclk);
        n++;
      end
      while (sync !== 1'h1 && n < 400)
      begin
        @(negedge pclk);
        n++;
      end
      if (n >= 400)
        error_cnt++;
    end
  endtask : wait_rise

  // one sync interval after a settling interval, edge to edge of sync (half a period in double mode)
  task automatic measure;
    logic last;
    begin
      wait_rise;
      wait_rise;
      {m_per, m_wid, m_ha, m_la, m_hb, m_hc, m_irq, m_mis} = '0;
      last = 1'h1;
      while (!(sync === 1'h1 && last === 1'h0) && m_per < 400)
      begin
        m_per++;
        m_wid += sync;
        m_ha += ah;
        m_la += al;
        m_hb += bh;
        m_hc += ch;
        m_irq += irq;
        m_mis += (csync !== sync);
        last = sync;
        @(negedge pclk);
      end
    end
  endtask : measure
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdchk(pwm_timing_pkg::off_sync_width, 32'h27);
    rdchk(pwm_timing_pkg::off_mode, 32'h0);
    apb(1'h0, 8'h28, 32'h0);
    check(er, 1'h1);
    apb(1'h1, pwm_timing_pkg::off_dead_time, 32'hffffffff);
    rdchk(pwm_timing_pkg::off_dead_time, 32'h3ff);
    apb(1'h1, pwm_timing_pkg::off_half_period, 32'hffffffff);
    rdchk(pwm_timing_pkg::off_half_period, 32'hffff);
    apb(1'h1, pwm_timing_pkg::off_duty_b, 32'hffffffff);
    rdchk(pwm_timing_pkg::off_duty_b, 32'hffff);
    apb(1'h1, pwm_timing_pkg::off_dead_time, 32'h0);
    apb(1'h1, pwm_timing_pkg::off_sync_width, 32'h2);
    apb(1'h1, pwm_timing_pkg::off_half_period, 32'ha);
    apb(1'h1, pwm_timing_pkg::off_duty_a, 32'h3);
    apb(1'h1, pwm_timing_pkg::off_duty_b, 32'h5);
    repeat (40) @(negedge pclk);
    check({ah, al, bh, bl, ch, cl, sync, irq}, 8'h0);
    apb(1'h1, pwm_timing_pkg::off_duty_c, 32'h7);
    $display("test reset done");
  endtask : t_reset

  task automatic t_single;
    measure;
    check(m_per, 20);
    check(m_wid, 3);
    check(m_ha, 6);
    check(m_la, 14);
    check(m_hb, 10);
    check(m_irq, 1);
    check(m_mis, 0);
    // a duty above the half period saturates at full on
    apb(1'h1, pwm_timing_pkg::off_duty_c, 32'hffff);
    measure;
    check(m_hc, 20);
    apb(1'h1, pwm_timing_pkg::off_duty_c, 32'h7);
    $display("test single done");
  endtask : t_single

  task automatic t_dead;
    apb(1'h1, pwm_timing_pkg::off_dead_time, 32'h1);
    measure;
    check(m_ha, 4);
    check(m_la, 12);
    check(m_hb, 8);
    check(m_hc, 12);
    check(shoot, 0);
    // narrowest sync pulse: width zero gives a single tick
    apb(1'h1, pwm_timing_pkg::off_sync_width, 32'h0);
    measure;
    check(m_wid, 1);
    $display("test dead done");
  endtask : t_dead

  task automatic t_segment;
    wait_rise;
    apb(1'h1, pwm_timing_pkg::off_segment, 32'h1a5);
    check(seg, 9'h0);
    wait_rise;
    repeat (2) @(negedge pclk);
    check(seg, 9'h1a5);
    $display("test segment done");
  endtask : t_segment

  task automatic t_double;
    logic s0;
    begin
      apb(1'h1, pwm_timing_pkg::off_mode, 32'h40);
      rdchk(pwm_timing_pkg::off_mode, 32'h40);
      measure;
      check(m_per, 10);
      check(m_irq, 1);
      wait_rise;
      apb(1'h0, pwm_timing_pkg::off_status, 32'h0);
      s0 = rd[3];
      check(rd[0], 1'h1);
      wait_rise;
      apb(1'h0, pwm_timing_pkg::off_status, 32'h0);
      check(rd[3] ^ s0, 1'h1);
      $display("test double done");
    end
  endtask : t_double
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'h0;
    presetn = 1'h0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    t_reset;
    t_single;
    t_dead;
    t_segment;
    t_double;
    close_out;
  end

  // whole run needs well under a thousand cycles
  initial
  begin
    #100us;
    error_cnt++;
    close_out;
  end
endmodule : three_phase_pwm_timing_unit_tb
`default_nettype wire
